// >>> core/pimg_pkg.sv
package pimg_pkg;

   // ------------------------------------------------------------
   // image geometry and address map
   // ------------------------------------------------------------
   localparam int          SLOTS           = 64;
   localparam logic [5:0]  LAST_SLOT       = 6'h3f;
   localparam logic [7:0]  LAST_WORD       = 8'hff;
   localparam logic [15:0] AREA_SPAN       = 16'h0100;
   localparam logic [15:0] OUT_MIRROR_BASE = 16'h0200;
   localparam logic [15:0] REG_IN_WORDS    = 16'h1000;
   localparam logic [15:0] REG_OUT_WORDS   = 16'h1001;
   localparam logic [15:0] REG_CONN_STAT   = 16'h1002;
   localparam logic [1:0]  MAX_MB_CONN     = 2'h3;
   localparam logic        MAX_WEB_CONN    = 1'b1;
   localparam logic        PENDING_RESET   = 1'b1;

   // ------------------------------------------------------------
   // module kinds and builder states
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      K_NONE = 3'h0, K_SSI = 3'h1, K_ENC = 3'h2, K_SER = 3'h3, K_SER5 = 3'h4, K_BITS = 3'h5
   } kind_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'h0, S_CLR = 2'h1, S_WORD = 2'h3, S_BIT = 2'h2
   } state_t;

   // words taken in the input area
   function automatic logic [2:0] in_words(kind_t k);
      case (k)
         K_SSI:   in_words = 3'h2;
         K_ENC:   in_words = 3'h4;
         K_SER:   in_words = 3'h2;
         K_SER5:  in_words = 3'h3;
         default: in_words = 3'h0;
      endcase
   endfunction

   // words taken in the output area; the absolute encoder has none
   function automatic logic [2:0] out_words(kind_t k);
      case (k)
         K_ENC:   out_words = 3'h4;
         K_SER:   out_words = 3'h2;
         K_SER5:  out_words = 3'h3;
         default: out_words = 3'h0;
      endcase
   endfunction

   // byte index (0 = control/status, n+1 = data byte n) to {valid, byte position}
   function automatic logic [3:0] byte_pos(kind_t k, logic [2:0] i);
      byte_pos = 4'h0;
      case (k)
         K_SSI:  if (i != 3'h0 && i <= 3'h4) byte_pos = {1'b1, i - 3'h1};
         K_SER:  if (i <= 3'h3) byte_pos = {1'b1, i};
         K_SER5: if (i <= 3'h5) byte_pos = {1'b1, i};
         K_ENC: begin
            case (i)
               3'h0:    byte_pos = 4'h8;
               3'h1:    byte_pos = 4'ha;
               3'h2:    byte_pos = 4'hb;
               3'h3:    byte_pos = 4'hc;
               3'h4:    byte_pos = 4'he;
               3'h5:    byte_pos = 4'hf;
               default: byte_pos = 4'h0;
            endcase
         end
         default: byte_pos = 4'h0;
      endcase
   endfunction

   // occupied bits of relative word w of a word-oriented module
   function automatic logic [15:0] word_mask(kind_t k, logic [1:0] w);
      if (k == K_ENC && !w[0]) word_mask = 16'h00ff;
      else word_mask = 16'hffff;
   endfunction

endpackage

// >>> core/conn_limiter.sv
`timescale 1ns/1ps
module conn_limiter (
   // clock and synchronised reset
   input  wire logic       clock,
   input  wire logic       rst_sync_b,
   // connection requests from the network stack
   input  wire logic       conn_open,
   input  wire logic       conn_close,
   input  wire logic       conn_web,
   // answers and counts
   output logic            conn_grant,
   output logic            conn_deny,
   output logic [1:0]      mb_count,
   output logic            web_count
);
   import pimg_pkg::*;

   logic full;

   // -------------------------------------------------------------
   // open and close bookkeeping
   // -------------------------------------------------------------
   // a refused open leaves the counts alone; the master must close first
   assign full = conn_web ? (web_count == MAX_WEB_CONN) : (mb_count == MAX_MB_CONN);

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         conn_grant <= 1'b0;
         conn_deny  <= 1'b0;
         mb_count   <= 2'h0;
         web_count  <= 1'b0;
      end else begin
         conn_grant <= conn_open && !full;
         conn_deny  <= conn_open && full;
         if (conn_open && !full) begin
            if (conn_web) web_count <= 1'b1;
            else mb_count <= mb_count + 2'h1;
         end else if (!conn_open && conn_close) begin
            // closing a connection that does not exist is ignored
            if (conn_web) web_count <= 1'b0;
            else if (mb_count != 2'h0) mb_count <= mb_count - 2'h1;
         end
      end
   end

   property p_mb_limit;
      @(posedge clock) disable iff (!rst_sync_b)
      (conn_open && !conn_web && mb_count == MAX_MB_CONN) |=> conn_deny && mb_count == 2'h3;
   endproperty
   a_mb_limit: assert property (p_mb_limit) else $error("fourth modbus connection taken");

   property p_web_limit;
      @(posedge clock) disable iff (!rst_sync_b)
      (conn_open && conn_web && web_count) |=> conn_deny && !conn_grant;
   endproperty
   a_web_limit: assert property (p_web_limit) else $error("second web connection taken");

endmodule

// >>> core/process_image_mapper.sv
// Operation
// - absolute encoder: input only, 4 data bytes in 2 words, bytes 1:0 low.
// - incremental encoder: 6 bytes in, 6 bytes out, 4 words each.
// - incremental encoder control/status byte sits in low byte of word 0.
// - encoder counter word in data bytes 1:0, latch word in bytes 4:3.
// - period measurement delivers period in data byte 2 beside bytes 4:3.
// - serial module: 2 words each way; c/s low, d0 high, then d2:d1.
// - five-byte serial variant: 3 words each way, d4:d3 in third word.
// - slave only: answers follow an accepted query, content by query type.
// - at most one web and three modbus connections; close before reopening.
// - separate input and output areas, words 0 to 255 each.
// - fieldbus reads input area; fieldbus writes drive the output modules.
// - output area mirrored for reading at offset 0x0200.
// - modules of a byte or more allocated first, physical order, from word 0.
// - bit modules then packed into bytes in order, next byte when full.
// - first digital channel at bit 0 up to fifteenth at bit 14.
// - internal registers from 0x1000, read only; writes answered with an error.
`timescale 1ns/1ps
module process_image_mapper (
   // clock and reset
   input  wire logic               clock,
   input  wire logic               rst_b,
   // configuration table from the module bus scan
   input  wire logic               cfg_wr,
   input  wire logic [5:0]         cfg_slot,
   input  wire pimg_pkg::kind_t    cfg_kind,
   input  wire logic [3:0]         cfg_in_bits,
   input  wire logic [3:0]         cfg_out_bits,
   // module bus data exchange
   input  wire logic               mod_wr,
   input  wire logic               mod_rd,
   input  wire logic [5:0]         mod_slot,
   input  wire logic [3:0]         mod_idx,
   input  wire logic [7:0]         mod_wdata,
   output logic [7:0]              mod_rdata,
   output logic                    mod_rvalid,
   // fieldbus queries
   input  wire logic               q_valid,
   input  wire logic               q_write,
   input  wire logic [15:0]        q_addr,
   input  wire logic [15:0]        q_wdata,
   output logic                    q_ready,
   output logic                    r_valid,
   output logic [15:0]             r_data,
   output logic                    r_err,
   // connection management
   input  wire logic               conn_open,
   input  wire logic               conn_close,
   input  wire logic               conn_web,
   output logic                    conn_grant,
   output logic                    conn_deny
);
   import pimg_pkg::*;

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [15:0]  in_img   [256];
   logic [15:0]  in_mask  [256];
   logic [15:0]  out_img  [256];
   logic [15:0]  out_mask [256];
   kind_t        kind_reg [SLOTS];
   logic [3:0]   bin_n    [SLOTS];
   logic [3:0]   bout_n   [SLOTS];
   logic [7:0]   in_base  [SLOTS];
   logic [7:0]   out_base [SLOTS];
   logic [11:0]  bin_base [SLOTS];
   logic [11:0]  bout_base[SLOTS];

   logic         rst_meta_b, rst_sync_b, pending_reg;
   logic [63:0]  slot_used_reg;
   state_t       state_reg;
   logic [5:0]   s_reg;
   logic [3:0]   c_reg;
   logic [7:0]   clr_reg;
   logic [8:0]   wptr_in_reg, wptr_out_reg, in_used_reg, out_used_reg;
   logic [12:0]  bptr_in_reg, bptr_out_reg;
   logic [1:0]   mb_count;
   logic         web_count;

   // all checks sample on the rising clock and sleep through reset
   default clocking dcb @(posedge clock); endclocking
   default disable iff (!rst_sync_b);

   // reset release through two flops
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end

   // table contents passed in, so callers re-evaluate when the table changes
   function automatic kind_t eff_kind(logic used, kind_t k);
      eff_kind = used ? k : K_NONE;
   endfunction

   // ----------------------------------------------------------------
   // configuration table
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (cfg_wr) begin
         kind_reg[cfg_slot] <= cfg_kind;
         bin_n[cfg_slot]    <= cfg_in_bits;
         bout_n[cfg_slot]   <= cfg_out_bits;
      end
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) slot_used_reg <= 64'h0;
      else if (cfg_wr) slot_used_reg[cfg_slot] <= 1'b1;
   end

   // a change during a build is not lost: set wins over the clear
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) pending_reg <= PENDING_RESET;
      else if (cfg_wr) pending_reg <= 1'b1;
      else if (state_reg == S_IDLE) pending_reg <= 1'b0;
   end

   // ----------------------------------------------------------------
   // allocation builder
   // ----------------------------------------------------------------
   kind_t       bk;
   logic [2:0]  iw, ow, mw;
   logic [3:0]  bi, bo, mb;
   logic        w_last, b_last;
   logic [8:0]  win_next, wout_next;
   logic [12:0] bend_in, bend_out, ba_in, ba_out;

   assign bk        = eff_kind(slot_used_reg[s_reg], kind_reg[s_reg]);
   assign iw        = in_words(bk);
   assign ow        = out_words(bk);
   assign mw        = (iw > ow) ? iw : ow;
   assign bi        = (bk == K_BITS) ? bin_n[s_reg] : 4'h0;
   assign bo        = (bk == K_BITS) ? bout_n[s_reg] : 4'h0;
   assign mb        = (bi > bo) ? bi : bo;
   assign w_last    = (mw == 3'h0) || (c_reg == {1'b0, mw - 3'h1});
   assign b_last    = (mb == 4'h0) || (c_reg == mb - 4'h1);
   assign win_next  = wptr_in_reg + {6'h0, iw};
   assign wout_next = wptr_out_reg + {6'h0, ow};
   assign bend_in   = bptr_in_reg + {9'h0, bi};
   assign bend_out  = bptr_out_reg + {9'h0, bo};
   assign ba_in     = bptr_in_reg + {9'h0, c_reg};
   assign ba_out    = bptr_out_reg + {9'h0, c_reg};
   assign q_ready   = (state_reg == S_IDLE);

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_reg    <= S_IDLE;
         s_reg        <= 6'h0;
         c_reg        <= 4'h0;
         clr_reg      <= 8'h0;
         wptr_in_reg  <= 9'h0;
         wptr_out_reg <= 9'h0;
         bptr_in_reg  <= 13'h0;
         bptr_out_reg <= 13'h0;
         in_used_reg  <= 9'h0;
         out_used_reg <= 9'h0;
      end else begin
         unique case (state_reg)
            S_IDLE: if (pending_reg) begin
               state_reg <= S_CLR;
               clr_reg   <= 8'h0;
            end
            S_CLR: begin
               clr_reg <= clr_reg + 8'h1;
               if (clr_reg == LAST_WORD) begin
                  state_reg    <= S_WORD;
                  s_reg        <= 6'h0;
                  c_reg        <= 4'h0;
                  wptr_in_reg  <= 9'h0;
                  wptr_out_reg <= 9'h0;
               end
            end
            S_WORD: if (w_last) begin
               c_reg        <= 4'h0;
               s_reg        <= s_reg + 6'h1;
               wptr_in_reg  <= win_next;
               wptr_out_reg <= wout_next;
               if (s_reg == LAST_SLOT) begin
                  state_reg    <= S_BIT;
                  bptr_in_reg  <= {win_next, 4'h0};
                  bptr_out_reg <= {wout_next, 4'h0};
               end
            end else c_reg <= c_reg + 4'h1;
            S_BIT: if (b_last) begin
               c_reg        <= 4'h0;
               s_reg        <= s_reg + 6'h1;
               bptr_in_reg  <= bend_in;
               bptr_out_reg <= bend_out;
               if (s_reg == LAST_SLOT) begin
                  state_reg    <= S_IDLE;
                  in_used_reg  <= 9'((bend_in + 13'h000f) >> 4);
                  out_used_reg <= 9'((bend_out + 13'h000f) >> 4);
               end
            end else c_reg <= c_reg + 4'h1;
         endcase
      end
   end

   // bases recorded on the first step of each slot
   always_ff @(posedge clock) begin
      if (state_reg == S_WORD && c_reg == 4'h0) begin
         in_base[s_reg]  <= wptr_in_reg[7:0];
         out_base[s_reg] <= wptr_out_reg[7:0];
      end
      if (state_reg == S_BIT && c_reg == 4'h0) begin
         bin_base[s_reg]  <= bptr_in_reg[11:0];
         bout_base[s_reg] <= bptr_out_reg[11:0];
      end
   end

   // occupancy masks; an image beyond 256 words wraps, no overflow flag
   always_ff @(posedge clock) begin
      if (state_reg == S_CLR) begin
         in_mask[clr_reg]  <= 16'h0;
         out_mask[clr_reg] <= 16'h0;
      end else if (state_reg == S_WORD) begin
         if ({1'b0, iw} > c_reg)
            in_mask[wptr_in_reg[7:0] + {4'h0, c_reg}] <= word_mask(bk, c_reg[1:0]);
         if ({1'b0, ow} > c_reg)
            out_mask[wptr_out_reg[7:0] + {4'h0, c_reg}] <= word_mask(bk, c_reg[1:0]);
      end else if (state_reg == S_BIT) begin
         if (bi > c_reg) in_mask[ba_in[11:4]][ba_in[3:0]] <= 1'b1;
         if (bo > c_reg) out_mask[ba_out[11:4]][ba_out[3:0]] <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // module bus side
   // ----------------------------------------------------------------
   kind_t       mk;
   logic [3:0]  mpos;
   logic        m_in_ok, m_out_ok, m_in_bit, m_out_bit;
   logic [7:0]  m_waddr, m_raddr;
   logic [11:0] m_bin, m_bout;

   assign mk        = eff_kind(slot_used_reg[mod_slot], kind_reg[mod_slot]);
   assign mpos      = mod_idx[3] ? 4'h0 : byte_pos(mk, mod_idx[2:0]);
   assign m_in_ok   = q_ready && mpos[3] && in_words(mk) != 3'h0;
   assign m_out_ok  = q_ready && mpos[3] && out_words(mk) != 3'h0;
   assign m_in_bit  = q_ready && mk == K_BITS && mod_idx < bin_n[mod_slot];
   assign m_out_bit = q_ready && mk == K_BITS && mod_idx < bout_n[mod_slot];
   assign m_waddr   = in_base[mod_slot] + {6'h0, mpos[2:1]};
   assign m_raddr   = out_base[mod_slot] + {6'h0, mpos[2:1]};
   assign m_bin     = bin_base[mod_slot] + {8'h0, mod_idx};
   assign m_bout    = bout_base[mod_slot] + {8'h0, mod_idx};

   // input image: cleared by the builder, filled by the modules
   always_ff @(posedge clock) begin
      if (state_reg == S_CLR) in_img[clr_reg] <= 16'h0;
      else if (mod_wr && m_in_ok) begin
         if (mpos[0]) in_img[m_waddr][15:8] <= mod_wdata;
         else in_img[m_waddr][7:0] <= mod_wdata;
      end else if (mod_wr && m_in_bit) in_img[m_bin[11:4]][m_bin[3:0]] <= mod_wdata[0];
   end

   // output module data; bit modules get their channel in bit 0
   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         mod_rdata  <= 8'h0;
         mod_rvalid <= 1'b0;
      end else begin
         mod_rvalid <= mod_rd && (m_out_ok || m_out_bit);
         if (mod_rd && m_out_ok)
            mod_rdata <= mpos[0] ? out_img[m_raddr][15:8] : out_img[m_raddr][7:0];
         else if (mod_rd && m_out_bit)
            mod_rdata <= {7'h0, out_img[m_bout[11:4]][m_bout[3:0]]};
      end
   end

   // ----------------------------------------------------------------
   // fieldbus side
   // ----------------------------------------------------------------
   logic       q_take, in_area, mirror;
   logic [7:0] qa;

   assign q_take  = q_valid && q_ready;
   assign qa      = q_addr[7:0];
   assign in_area = q_addr < AREA_SPAN;
   assign mirror  = q_addr >= OUT_MIRROR_BASE && q_addr < OUT_MIRROR_BASE + AREA_SPAN;

   // unoccupied bits never latch, so the mirror reads zero there
   always_ff @(posedge clock) begin
      if (state_reg == S_CLR) out_img[clr_reg] <= 16'h0;
      else if (q_take && q_write && in_area) out_img[qa] <= q_wdata & out_mask[qa];
   end

   always_ff @(posedge clock or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         r_valid <= 1'b0;
         r_data  <= 16'h0;
         r_err   <= 1'b0;
      end else begin
         r_valid <= q_take;
         if (q_take && q_write) begin
            r_data <= 16'h0;
            r_err  <= !in_area;
         end else if (q_take) begin
            r_err  <= 1'b0;
            if (in_area) r_data <= in_img[qa] & in_mask[qa];
            else if (mirror) r_data <= out_img[qa];
            else if (q_addr == REG_IN_WORDS) r_data <= {7'h0, in_used_reg};
            else if (q_addr == REG_OUT_WORDS) r_data <= {7'h0, out_used_reg};
            else if (q_addr == REG_CONN_STAT) r_data <= {12'h0, web_count, 1'b0, mb_count};
            else begin
               r_data <= 16'h0;
               r_err  <= 1'b1;
            end
         end
      end
   end

   conn_limiter u_conn (
      .clock      (clock),
      .rst_sync_b (rst_sync_b),
      .conn_open  (conn_open),
      .conn_close (conn_close),
      .conn_web   (conn_web),
      .conn_grant (conn_grant),
      .conn_deny  (conn_deny),
      .mb_count   (mb_count),
      .web_count  (web_count)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_answer_after_query; r_valid |-> $past(q_take); endproperty
   a_answer_after_query: assert property (p_answer_after_query) else $error("unasked answer");

   property p_mirror_readonly; (q_take && q_write && mirror) |=> r_valid && r_err; endproperty
   a_mirror_readonly: assert property (p_mirror_readonly) else $error("mirror write taken");

   property p_out_write_ok; (q_take && q_write && in_area) |=> r_valid && !r_err; endproperty
   a_out_write_ok: assert property (p_out_write_ok) else $error("output write refused");

   property p_unoccupied_zero;
      (q_take && !q_write && in_area && in_mask[qa] == 16'h0) |=> r_data == 16'h0; endproperty
   a_unoccupied_zero: assert property (p_unoccupied_zero) else $error("empty bits read");

   property p_rebuild; (cfg_wr && state_reg == S_IDLE) |=> ##1 state_reg == S_CLR; endproperty
   a_rebuild: assert property (p_rebuild) else $error("no rebuild on change");

   property p_word_from_zero;
      $rose(state_reg == S_WORD) |-> wptr_in_reg == 9'h0 && s_reg == 6'h0 && c_reg == 4'h0;
   endproperty
   a_word_from_zero: assert property (p_word_from_zero) else $error("word pass start");

   property p_bits_after_words;
      $rose(state_reg == S_BIT) |-> bptr_in_reg == {wptr_in_reg, 4'h0}; endproperty
   a_bits_after_words: assert property (p_bits_after_words) else $error("bit pass start");

   property p_enc_cs_low;
      (m_in_ok && mk == K_ENC && mod_idx == 4'h0) |-> m_waddr == in_base[mod_slot] && !mpos[0];
   endproperty
   a_enc_cs_low: assert property (p_enc_cs_low) else $error("encoder c/s misplaced");

   property p_ssi_top;
      (m_in_ok && mk == K_SSI && mod_idx == 4'h4) |->
         m_waddr == in_base[mod_slot] + 8'h1 && mpos[0];
   endproperty
   a_ssi_top: assert property (p_ssi_top) else $error("ssi byte 3 misplaced");

   property p_ser_d0_high;
      (m_in_ok && mk == K_SER && mod_idx == 4'h1) |-> m_waddr == in_base[mod_slot] && mpos[0];
   endproperty
   a_ser_d0_high: assert property (p_ser_d0_high) else $error("serial d0 misplaced");

endmodule

// >>> tb/fieldbus_master.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// network master stand-in: one query at a time, never unasked
// ------------------------------------------------------------
module fieldbus_master (
   // clock
   input  wire logic        clock,
   // query side
   output logic             q_valid = 1'b0,
   output logic             q_write = 1'b0,
   output logic [15:0]      q_addr  = 16'h0,
   output logic [15:0]      q_wdata = 16'h0,
   input  wire logic        q_ready,
   // answer side
   input  wire logic        r_valid,
   input  wire logic [15:0] r_data,
   input  wire logic        r_err
);
   // query held until the taking edge; answer looked at on the falling edge after it
   task automatic query(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rd, output logic e, output logic ok);
      int n;
      n = 0;
      @(posedge clock);
      q_valid <= 1'b1;
      q_write <= w;
      q_addr  <= a;
      q_wdata <= w ? d : ~q_wdata; // stale data would hide a missing write-enable
      @(negedge clock);
      while (q_ready !== 1'b1 && n < 2000) begin
         @(negedge clock);
         n++;
      end
      @(posedge clock);
      q_valid <= 1'b0;
      @(negedge clock);
      ok = (n < 2000) && (r_valid === 1'b1);
      rd = r_data;
      e  = r_err;
   endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
   import pimg_pkg::*;
   // ------------------------------------------------------------
   // clock, reset and stimulus
   // ------------------------------------------------------------
   logic        clock = 1'b0, rst_b = 1'b0, cfg_wr = 1'b0, mod_wr = 1'b0, mod_rd = 1'b0;
   logic        conn_open = 1'b0, conn_close = 1'b0, conn_web = 1'b0;
   logic [5:0]  cfg_slot = 6'h0, mod_slot = 6'h0;
   kind_t       cfg_kind = K_NONE;
   logic [3:0]  cfg_in_bits = 4'h0, cfg_out_bits = 4'h0, mod_idx = 4'h0;
   logic [7:0]  mod_wdata = 8'h0, mod_rdata;
   logic        mod_rvalid, q_valid, q_write, q_ready, r_valid, r_err, conn_grant, conn_deny;
   logic [15:0] q_addr, q_wdata, r_data;
   int          failures = 0, cmp_count = 0;
   always #5 clock = ~clock;
   process_image_mapper i_dut (.clock, .rst_b, .cfg_wr, .cfg_slot, .cfg_kind, .cfg_in_bits,
      .cfg_out_bits, .mod_wr, .mod_rd, .mod_slot, .mod_idx, .mod_wdata, .mod_rdata,
      .mod_rvalid, .q_valid, .q_write, .q_addr, .q_wdata, .q_ready, .r_valid, .r_data,
      .r_err, .conn_open, .conn_close, .conn_web, .conn_grant, .conn_deny);
   fieldbus_master i_mst (.clock, .q_valid, .q_write, .q_addr, .q_wdata, .q_ready,
      .r_valid, .r_data, .r_err);
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // a lost answer counts as a mismatch and closes the run
   task automatic fb(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic [15:0] exp, input logic exp_err);
      logic [15:0] rd;
      logic        e, ok;
      i_mst.query(w, a, d, rd, e, ok);
      if (!ok) begin
         failures++;
         end_of_test();
      end
      check({15'h0, e}, {15'h0, exp_err});
      if (!w) check(rd, exp);
   endtask
   // the builder may still be idle for an edge after a config write
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(posedge clock);
      @(negedge clock);
      while (q_ready !== 1'b1 && n < 5000) begin
         @(negedge clock);
         n++;
      end
      if (n >= 5000) begin
         failures++;
         end_of_test();
      end
   endtask
   task automatic cfg(input logic [5:0] s, input kind_t k, input logic [3:0] nb);
      @(posedge clock);
      cfg_wr <= 1'b1;
      cfg_slot <= s;
      cfg_kind <= k;
      cfg_in_bits <= nb;
      cfg_out_bits <= nb;
      @(posedge clock);
      cfg_wr <= 1'b0;
   endtask
   task automatic modx(input logic rd, input logic [5:0] s, input logic [3:0] i,
                       input logic [7:0] d);
      @(posedge clock);
      mod_wr <= !rd;
      mod_rd <= rd;
      mod_slot <= s;
      mod_idx <= i;
      mod_wdata <= d;
      @(posedge clock);
      mod_wr <= 1'b0;
      mod_rd <= 1'b0;
      @(negedge clock);
   endtask
   task automatic conn(input logic web, input logic [1:0] exp);
      @(posedge clock);
      conn_open <= 1'b1;
      conn_web <= web;
      @(posedge clock);
      conn_open <= 1'b0;
      @(negedge clock);
      check({14'h0, conn_grant, conn_deny}, {14'h0, exp});
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_in_map();
      logic [15:0] exp [12] = '{16'h1211, 16'h1413, 16'h0020, 16'h2221, 16'h0023, 16'h2524,
                               16'h3130, 16'h3332, 16'h4140, 16'h4342, 16'h4544, 16'h014a};
      int lo [6] = '{0, 1, 0, 0, 0, 0};
      int hi [6] = '{4, 4, 5, 3, 5, 3};
      for (int s = 0; s < 6; s++)
         for (int i = lo[s]; i <= hi[s]; i++)
            modx(1'b0, 6'(s), 4'(i), {4'(s), 4'(i)});
      for (int w = 0; w < 12; w++)
         fb(1'b0, 16'(w), 16'h0, exp[w], 1'b0);
      fb(1'b0, 16'h000c, 16'h0, 16'h0, 1'b0);
      fb(1'b0, 16'h0100, 16'h0, 16'h0, 1'b1);
      fb(1'b0, 16'h1000, 16'h0, 16'h000c, 1'b0);
      fb(1'b0, 16'h1001, 16'h0, 16'h000a, 1'b0);
      $display("test in_map done");
   endtask
   task automatic t_out_map();
      fb(1'b1, 16'h0004, 16'hbeef, 16'h0, 1'b0);
      modx(1'b1, 6'h03, 4'h0, 8'h0);
      check({mod_rvalid, 7'h0, mod_rdata}, 16'h80ef);
      modx(1'b1, 6'h03, 4'h1, 8'h0);
      check({mod_rvalid, 7'h0, mod_rdata}, 16'h80be);
      modx(1'b1, 6'h01, 4'h1, 8'h0);
      check({15'h0, mod_rvalid}, 16'h0);
      fb(1'b1, 16'h0000, 16'hffff, 16'h0, 1'b0);
      fb(1'b0, 16'h0200, 16'h0, 16'h00ff, 1'b0);
      fb(1'b1, 16'h0009, 16'hffff, 16'h0, 1'b0);
      fb(1'b0, 16'h0209, 16'h0, 16'h01ff, 1'b0);
      modx(1'b1, 6'h05, 4'h3, 8'h0);
      check({14'h0, mod_rvalid, mod_rdata[0]}, 16'h0003);
      fb(1'b1, 16'h0200, 16'h1234, 16'h0, 1'b1);
      fb(1'b1, 16'h1000, 16'h1234, 16'h0, 1'b1);
      $display("test out_map done");
   endtask
   task automatic t_conn();
      repeat (3) conn(1'b0, 2'b10);
      conn(1'b0, 2'b01);
      conn(1'b1, 2'b10);
      conn(1'b1, 2'b01);
      fb(1'b0, 16'h1002, 16'h0, 16'h000b, 1'b0);
      @(posedge clock);
      conn_close <= 1'b1;
      conn_web <= 1'b0;
      @(posedge clock);
      conn_close <= 1'b0;
      conn(1'b0, 2'b10);
      $display("test conn done");
   endtask
   task automatic t_rebuild();
      cfg(6'h01, K_NONE, 4'h0);
      wait_idle();
      fb(1'b0, 16'h1000, 16'h0, 16'h000a, 1'b0);
      fb(1'b0, 16'h0000, 16'h0, 16'h0, 1'b0);
      $display("test rebuild done");
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      // table writes before the internal reset lets go would be lost
      repeat (3) @(posedge clock);
      cfg(6'h00, K_BITS, 4'h5);
      cfg(6'h01, K_SSI, 4'h0);
      cfg(6'h02, K_ENC, 4'h0);
      cfg(6'h03, K_SER, 4'h0);
      cfg(6'h04, K_SER5, 4'h0);
      cfg(6'h05, K_BITS, 4'h4);
      // writes during a build leave one idle cycle before the rebuild
      wait_idle();
      wait_idle();
      t_in_map();
      t_out_map();
      t_conn();
      t_rebuild();
      end_of_test();
   end
endmodule
